// ### hw/rcad_pkg.sv
`default_nettype none
package rcad_pkg;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int unsigned INSTR_W    = 14;
   localparam int unsigned PC_W       = 13;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned FILE_AW    = 9;
   localparam int unsigned FILE_DEPTH = 512;
   localparam int unsigned PROG_WORDS = 8192;

   // ----------------------------------------------------------------
   // timing: one instruction cycle is a whole number of oscillator clocks
   // ----------------------------------------------------------------
   localparam int unsigned CYCLE_NS_AT_MAX = 200;
   localparam int unsigned OSC_MAX_MHZ     = 20;
   localparam int unsigned OSC_PER_CYCLE   =
      (CYCLE_NS_AT_MAX * OSC_MAX_MHZ) / 1000;

   // ----------------------------------------------------------------
   // special function registers (low seven address bits, all banks)
   // ----------------------------------------------------------------
   localparam logic [6:0] SFR_INDF   = 7'h00;
   localparam logic [6:0] SFR_PCL    = 7'h02;
   localparam logic [6:0] SFR_STATUS = 7'h03;
   localparam logic [6:0] SFR_FSR    = 7'h04;
   localparam logic [6:0] SFR_PCLATH = 7'h0a;

   localparam int unsigned ST_C   = 0;
   localparam int unsigned ST_DC  = 1;
   localparam int unsigned ST_Z   = 2;
   localparam int unsigned ST_RP0 = 5;
   localparam int unsigned ST_RP1 = 6;
   localparam int unsigned ST_IRP = 7;

   localparam logic [7:0]  STATUS_RST = 8'h00;
   localparam logic [7:0]  FSR_RST    = 8'h00;
   localparam logic [7:0]  PCLATH_RST = 8'h00;
   localparam logic [12:0] PC_RST     = 13'h0000;
   localparam logic [7:0]  W_RST      = 8'h00;
   localparam logic [13:0] NOP_WORD   = 14'h0000;

   // ----------------------------------------------------------------
   // instruction classes and alu operations
   // ----------------------------------------------------------------
   localparam logic [1:0] CLS_FILE  = 2'b00;
   localparam logic [1:0] CLS_LIT   = 2'b01;
   localparam logic [1:0] CLS_GOTO  = 2'b10;
   localparam logic [1:0] CLS_GOTOZ = 2'b11;

   typedef enum logic [3:0] {
      ALU_NOP  = 4'b0000, ALU_ADD  = 4'b0001, ALU_SUB  = 4'b0010,
      ALU_AND  = 4'b0011, ALU_IOR  = 4'b0100, ALU_XOR  = 4'b0101,
      ALU_RLF  = 4'b0110, ALU_RRF  = 4'b0111, ALU_COM  = 4'b1000,
      ALU_INC  = 4'b1001, ALU_DEC  = 4'b1010, ALU_PASS = 4'b1011,
      ALU_MOVW = 4'b1100, ALU_CLR  = 4'b1101, ALU_SWAP = 4'b1110,
      ALU_LOAD = 4'b1111
   } rcad_alu_op_t;

   typedef enum logic [1:0] {
      PH_Q1 = 2'b00, PH_Q2 = 2'b01, PH_Q3 = 2'b10, PH_Q4 = 2'b11
   } rcad_phase_t;

   typedef struct packed {
      logic z;
      logic dc;
      logic c;
   } rcad_flags_t;

   typedef struct packed {
      logic [1:0]   cls;
      rcad_alu_op_t op;
      logic         dst;
      logic [6:0]   fad;
   } rcad_instr_t;
endpackage
`default_nettype wire

// ### hw/rcad_alu.sv
`default_nettype none
module rcad_alu
   import rcad_pkg::*;
(
   input  wire logic [7:0]             a_i,   // working accumulator
   input  wire logic [7:0]             b_i,   // file register or literal
   input  wire rcad_pkg::rcad_alu_op_t op_i,  // operation
   input  wire logic                   c_i,   // carry in
   output logic [7:0]                  y_o,   // result
   output rcad_pkg::rcad_flags_t       fl_o,  // new flag values
   output rcad_pkg::rcad_flags_t       upd_o  // flags this operation touches
);
   timeunit 1ns;
   timeprecision 1ns;
   import rcad_pkg::*;

   // ----------------------------------------------------------------
   // adder shared by byte and nibble paths
   // ----------------------------------------------------------------
   function automatic logic [8:0] add_c(input logic [7:0] x,
                                        input logic [7:0] y,
                                        input logic       ci);
      add_c = {1'b0, x} + {1'b0, y} + {8'h00, ci};
   endfunction

   logic [8:0] sum;
   logic [8:0] nib;

   always_comb begin
      sum   = 9'h000;
      nib   = 9'h000;
      y_o   = b_i;
      fl_o  = '0;
      upd_o = '0;
      case (op_i)
         ALU_ADD: begin
            sum   = add_c(a_i, b_i, 1'b0);
            nib   = add_c({4'h0, a_i[3:0]}, {4'h0, b_i[3:0]}, 1'b0);
            y_o   = sum[7:0];
            upd_o = '{z: 1'b1, dc: 1'b1, c: 1'b1};
         end
         // twos complement borrow: b - a as b + ~a + 1
         ALU_SUB: begin
            sum   = add_c(b_i, ~a_i, 1'b1);
            nib   = add_c({4'h0, b_i[3:0]}, {4'h0, ~a_i[3:0]}, 1'b1);
            y_o   = sum[7:0];
            upd_o = '{z: 1'b1, dc: 1'b1, c: 1'b1};
         end
         ALU_AND: begin
            y_o   = a_i & b_i;
            upd_o.z = 1'b1;
         end
         ALU_IOR: begin
            y_o   = a_i | b_i;
            upd_o.z = 1'b1;
         end
         ALU_XOR: begin
            y_o   = a_i ^ b_i;
            upd_o.z = 1'b1;
         end
         // rotates go through carry
         ALU_RLF: begin
            y_o     = {b_i[6:0], c_i};
            sum[8]  = b_i[7];
            upd_o.c = 1'b1;
         end
         ALU_RRF: begin
            y_o     = {c_i, b_i[7:1]};
            sum[8]  = b_i[0];
            upd_o.c = 1'b1;
         end
         ALU_COM: begin
            y_o   = ~b_i;
            upd_o.z = 1'b1;
         end
         ALU_INC: begin
            y_o   = b_i + 8'h01;
            upd_o.z = 1'b1;
         end
         ALU_DEC: begin
            y_o   = b_i - 8'h01;
            upd_o.z = 1'b1;
         end
         ALU_PASS: begin
            y_o   = b_i;
            upd_o.z = 1'b1;
         end
         ALU_MOVW: y_o = a_i;
         ALU_CLR: begin
            y_o   = 8'h00;
            upd_o.z = 1'b1;
         end
         ALU_SWAP: y_o = {b_i[3:0], b_i[7:4]};
         default: y_o = b_i;
      endcase
      fl_o.c  = sum[8];
      fl_o.dc = nib[4];
      fl_o.z  = (y_o == 8'h00);
   end
endmodule
`default_nettype wire

// ### hw/rcad_core.sv
`default_nettype none
// Operation
// - every instruction is one 14-bit word
// - a 14-bit program bus brings one whole word each cycle
// - fetch of the next word overlaps execution of the current one
// - non-branch instructions take one cycle of four oscillator clocks
// - 13-bit counter reaches up to 8K words of on-chip program memory
// - program and data sit on separate buses and widths
// - special registers, counter included, live in the data space
// - file space is reached directly or indirectly through a pointer
// - every operation works on every file register alike
// - 8-bit alu adds, subtracts, shifts and does logic
// - arithmetic is twos complement
// - two-operand work uses accumulator and file or literal
// - single-operand work uses accumulator or a file register
// - accumulator is 8 bits and has no data address
// - alu updates carry, digit carry and zero as the operation says
// - in subtraction a set carry or digit carry means no borrow
// - in rc mode the clock output runs at a quarter of the oscillator
// - master clear low resets; outside holds it high to run
module rcad_core
   import rcad_pkg::*;
(
   input  wire logic               ref_clk_i,   // oscillator input
   input  wire logic               rst_i,       // async reset
   input  wire logic               master_clear_n_i, // pin, low resets
   input  wire logic               resistor_capacitor_oscillator_mode_i, // pin
   input  wire logic [INSTR_W-1:0] pmem_data_i, // program word
   output logic [PC_W-1:0]         pmem_addr_o, // program address
   output logic                    instruction_rate_clock_out_o, // q/4
   output logic [DATA_W-1:0]       w_acc_o,     // accumulator
   output logic [DATA_W-1:0]       status_o     // status register
);
   timeunit 1ns;
   timeprecision 1ns;
   import rcad_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic master_clear_n_s1_reg;
   logic master_clear_n_s2_reg;
   logic rc_s1_reg;
   logic rc_s2_reg;

   // held in reset until a high pin has passed both synchroniser stages
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         master_clear_n_s1_reg <= 1'b0;
         master_clear_n_s2_reg <= 1'b0;
         rc_s1_reg   <= 1'b0;
         rc_s2_reg   <= 1'b0;
      end else begin
         master_clear_n_s1_reg <= master_clear_n_i;
         master_clear_n_s2_reg <= master_clear_n_s1_reg;
         rc_s1_reg   <= resistor_capacitor_oscillator_mode_i;
         rc_s2_reg   <= rc_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   rcad_phase_t        phase_reg,   phase_next;
   logic [PC_W-1:0]    pc_reg,      pc_next;
   logic [INSTR_W-1:0] ir_reg,      ir_next;
   logic               ir_valid_reg, ir_valid_next;
   logic [7:0]         w_reg,       w_next;
   logic [7:0]         status_reg,  status_next;
   logic [7:0]         fsr_reg,     fsr_next;
   logic [7:0]         pclath_reg,  pclath_next;
   logic               instruction_rate_clock_out_reg,  instruction_rate_clock_out_next;

   // general purpose file registers; sfr addresses are shadowed
   logic [7:0] file_mem [FILE_DEPTH];

   rcad_instr_t         ins;
   logic                run;
   logic                exec_end;
   logic [FILE_AW-1:0]  eaddr;
   logic [7:0]          fread;
   logic [7:0]          alu_b;
   logic [7:0]          alu_y;
   rcad_flags_t         alu_fl;
   rcad_flags_t         alu_upd;
   logic                do_exec;
   logic                wr_file;
   logic                wr_mem;
   logic                taken;
   logic [PC_W-1:0]     target;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // direct uses bank bits, indirect uses the pointer register
   function automatic logic [FILE_AW-1:0] file_addr(input logic [6:0] f,
                                                   input logic [7:0] st,
                                                   input logic [7:0] fsr);
      if (f == SFR_INDF) begin
         file_addr = {st[ST_IRP], fsr};
      end else begin
         file_addr = {st[ST_RP1], st[ST_RP0], f};
      end
   endfunction

   function automatic logic is_sfr(input logic [FILE_AW-1:0] a,
                                   input logic [6:0]         code);
      is_sfr = (a[6:0] == code);
   endfunction

   // ----------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------
   // the fetched word is decoded as one whole instruction
   assign ins      = rcad_instr_t'(ir_reg);
   assign run      = master_clear_n_s2_reg;
   assign exec_end = (phase_reg == PH_Q4);
   assign eaddr    = file_addr(ins.fad, status_reg, fsr_reg);

   // one read mux covers special and plain registers
   always_comb begin
      if (is_sfr(eaddr, SFR_INDF)) begin
         fread = 8'h00;
      end else if (is_sfr(eaddr, SFR_PCL)) begin
         fread = pc_reg[7:0];
      end else if (is_sfr(eaddr, SFR_STATUS)) begin
         fread = status_reg;
      end else if (is_sfr(eaddr, SFR_FSR)) begin
         fread = fsr_reg;
      end else if (is_sfr(eaddr, SFR_PCLATH)) begin
         fread = pclath_reg;
      end else begin
         fread = file_mem[eaddr];
      end
   end

   // second operand is the file or the literal
   assign alu_b = (ins.cls == CLS_LIT) ? {ins.dst, ins.fad} : fread;

   // eight bit alu between accumulator and operand
   rcad_alu u_alu (
      .a_i   (w_reg),
      .b_i   (alu_b),
      .op_i  (ins.op),
      .c_i   (status_reg[ST_C]),
      .y_o   (alu_y),
      .fl_o  (alu_fl),
      .upd_o (alu_upd)
   );

   assign do_exec = run && exec_end && ir_valid_reg &&
                    ins.cls[1] == 1'b0 && ins.op != ALU_NOP;
   assign wr_file = do_exec && ins.cls == CLS_FILE && ins.dst;
   assign wr_mem  = wr_file && !is_sfr(eaddr, SFR_INDF) &&
                    !is_sfr(eaddr, SFR_PCL) && !is_sfr(eaddr, SFR_STATUS) &&
                    !is_sfr(eaddr, SFR_FSR) && !is_sfr(eaddr, SFR_PCLATH);

   // ----------------------------------------------------------------
   // flow control
   // ----------------------------------------------------------------
   always_comb begin
      taken  = 1'b0;
      target = pc_reg;
      if (run && exec_end && ir_valid_reg) begin
         if (ins.cls == CLS_GOTO ||
             (ins.cls == CLS_GOTOZ && status_reg[ST_Z])) begin
            taken  = 1'b1;
            target = {pclath_reg[4:3], ir_reg[10:0]};
         end else if (wr_file && is_sfr(eaddr, SFR_PCL)) begin
            taken  = 1'b1;
            target = {pclath_reg[4:0], alu_y};
         end
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      phase_next    = phase_reg;
      pc_next       = pc_reg;
      ir_next       = ir_reg;
      ir_valid_next = ir_valid_reg;
      w_next        = w_reg;
      status_next   = status_reg;
      fsr_next      = fsr_reg;
      pclath_next   = pclath_reg;
      // master clear low holds the core at its start point
      if (!run) begin
         phase_next    = PH_Q1;
         pc_next       = PC_RST;
         ir_next       = NOP_WORD;
         ir_valid_next = 1'b0;
         status_next   = STATUS_RST;
         fsr_next      = FSR_RST;
         pclath_next   = PCLATH_RST;
      end else begin
         // four oscillator clocks per instruction cycle
         case (phase_reg)
            PH_Q1:   phase_next = PH_Q2;
            PH_Q2:   phase_next = PH_Q3;
            PH_Q3:   phase_next = PH_Q4;
            default: phase_next = PH_Q1;
         endcase
         if (exec_end) begin
            // word fetched this cycle becomes next to execute
            if (taken) begin
               // drop the fetched word, refetch from the target
               ir_next       = NOP_WORD;
               ir_valid_next = 1'b0;
               pc_next       = target;
            end else begin
               ir_next       = pmem_data_i;
               ir_valid_next = 1'b1;
               // counter wraps over the whole program space
               pc_next       = pc_reg + 13'h0001;
            end
         end
         if (do_exec) begin
            // accumulator written only as a destination
            if (!wr_file) begin
               w_next = alu_y;
            end
            if (wr_file && is_sfr(eaddr, SFR_STATUS)) begin
               status_next = alu_y;
            end
            if (wr_file && is_sfr(eaddr, SFR_FSR)) begin
               fsr_next = alu_y;
            end
            if (wr_file && is_sfr(eaddr, SFR_PCLATH)) begin
               pclath_next = alu_y;
            end
            // flag update wins over an explicit write
            if (alu_upd.c) begin
               status_next[ST_C] = alu_fl.c;
            end
            if (alu_upd.dc) begin
               status_next[ST_DC] = alu_fl.dc;
            end
            if (alu_upd.z) begin
               status_next[ST_Z] = alu_fl.z;
            end
         end
      end
   end

   // high for the second half of each cycle in rc mode only
   assign instruction_rate_clock_out_next = rc_s2_reg && phase_next[1];

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_reg    <= PH_Q1;
         pc_reg       <= PC_RST;
         ir_reg       <= NOP_WORD;
         ir_valid_reg <= 1'b0;
         w_reg        <= W_RST;
         status_reg   <= STATUS_RST;
         fsr_reg      <= FSR_RST;
         pclath_reg   <= PCLATH_RST;
         instruction_rate_clock_out_reg   <= 1'b0;
      end else begin
         phase_reg    <= phase_next;
         pc_reg       <= pc_next;
         ir_reg       <= ir_next;
         ir_valid_reg <= ir_valid_next;
         w_reg        <= w_next;
         status_reg   <= status_next;
         fsr_reg      <= fsr_next;
         pclath_reg   <= pclath_next;
         instruction_rate_clock_out_reg   <= instruction_rate_clock_out_next;
      end
   end

   // no reset on the array: contents are undefined until written
   // data space written apart from the program bus
   always_ff @(posedge ref_clk_i) begin
      if (wr_mem) begin
         file_mem[eaddr] <= alu_y;
      end
   end

   assign pmem_addr_o                  = pc_reg;
   assign instruction_rate_clock_out_o = instruction_rate_clock_out_reg;
   assign w_acc_o                      = w_reg;
   assign status_o                     = status_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   phase_cycle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (run && phase_reg == PH_Q1) |=> (phase_reg == PH_Q2))
      else $error("phase did not advance");

   instruction_rate_clock_out_rate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      instruction_rate_clock_out_o == ($past(rc_s2_reg) && phase_reg[1]))
      else $error("clock out not at quarter rate");

   fetch_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (run && exec_end && !taken) |=> (pc_reg == $past(pc_reg) + 13'h0001
         || !$past(run)))
      else $error("fetch address did not step");

   branch_flush_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      taken |=> !ir_valid_reg ##3 (!ir_valid_reg && pc_reg == $past(target, 4)))
      else $error("branch did not flush the fetched word");

   zero_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (do_exec && alu_upd.z) |=> status_reg[ST_Z] == ($past(alu_y) == 8'h00))
      else $error("zero flag wrong");

   w_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !exec_end |=> $stable(w_reg))
      else $error("accumulator changed mid cycle");

   sub_borrow_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (do_exec && ins.op == ALU_SUB) |=>
         status_reg[ST_C] == ($past(alu_b) >= $past(w_reg)))
      else $error("borrow flag wrong");

   master_clear_n_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !run |=> (pc_reg == PC_RST && !ir_valid_reg && phase_reg == PH_Q1))
      else $error("master clear did not reset core");

   one_cycle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (run && exec_end && !taken) ##1 run [*4] |-> ir_valid_reg)
      else $error("plain instruction stalled");
endmodule
`default_nettype wire

// ### test/rcad_pmem_model.sv
`default_nettype none
// ----------------------------------------------------------------
// program memory model
// ----------------------------------------------------------------
module rcad_pmem_model
   import rcad_pkg::*;
#(
   parameter int unsigned LAT = 1  // settle clocks, 1 is the slowest legal
)(
   input  wire logic               clk_i,   // oscillator clock
   input  wire logic [PC_W-1:0]    addr_i,  // fetch address
   output logic [INSTR_W-1:0]      data_o   // program word
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [INSTR_W-1:0] mem [PROG_WORDS];
   logic [PC_W-1:0]    last_q = '0;
   int unsigned        wait_q = 0;

   initial begin
      for (int i = 0; i < PROG_WORDS; i++)
         mem[i] = NOP_WORD;
   end

   always @(posedge clk_i) begin
      if (addr_i !== last_q) begin
         // garbled while settling so a stale word is never taken
         last_q <= addr_i;
         wait_q <= 0;
         data_o <= ~data_o;
      end else if (wait_q < LAT) begin
         wait_q <= wait_q + 1;
      end else begin
         data_o <= mem[addr_i];
      end
   end
endmodule
`default_nettype wire

// ### test/tb_risc_core_alu_datapath.sv
`default_nettype none
module tb_risc_core_alu_datapath;
   timeunit 1ns;
   timeprecision 1ns;
   import rcad_pkg::*;

   localparam int unsigned NRAND = 24;
   localparam int unsigned LAST  = 48;

   logic               ref_clk_i = 1'b0;
   logic               rst_i     = 1'b1;
   logic               master_clear_n_n    = 1'b1;
   logic               rc_mode   = 1'b1;
   logic               run_chk   = 1'b0;
   logic [INSTR_W-1:0] pmem_data;
   logic [PC_W-1:0]    pmem_addr;
   logic               clk_out;
   logic [DATA_W-1:0]  w_acc;
   logic [DATA_W-1:0]  status;
   logic [28:0]        notes [$];
   logic [7:0]         ew;
   rcad_flags_t        ef;
   int                 miscompares = 0;
   int                 check_count = 0;
   integer             seed = 32'hac46;
   logic [3:0]         ops [6] = '{4'hf, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};

   always #5 ref_clk_i = ~ref_clk_i;

   rcad_core DUT (
      .ref_clk_i                            (ref_clk_i),
      .rst_i                                (rst_i),
      .master_clear_n_i                     (master_clear_n_n),
      .resistor_capacitor_oscillator_mode_i (rc_mode),
      .pmem_data_i                          (pmem_data),
      .pmem_addr_o                          (pmem_addr),
      .instruction_rate_clock_out_o         (clk_out),
      .w_acc_o                              (w_acc),
      .status_o                             (status)
   );

   rcad_pmem_model #(.LAT(1)) u_mem (
      .clk_i  (ref_clk_i),
      .addr_i (pmem_addr),
      .data_o (pmem_data)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report;
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // expected accumulator and flags after one literal instruction
   task automatic exec(input logic [13:0] wd);
      logic [8:0] s;
      logic [7:0] b;
      b = wd[7:0];
      case (wd[11:8])
         4'h1: begin
            s = {1'b0, ew} + {1'b0, b};
            ef.dc = 5'({1'b0, ew[3:0]} + {1'b0, b[3:0]}) > 5'd15;
            ef.c = s[8];
            ew = s[7:0];
         end
         4'h2: begin
            ef.c = b >= ew;
            ef.dc = b[3:0] >= ew[3:0];
            ew = b - ew;
         end
         4'h3: ew = ew & b;
         4'h4: ew = ew | b;
         4'h5: ew = ew ^ b;
         default: ew = b;
      endcase
      if (wd[11:8] != 4'hf)
         ef.z = (ew == 8'h00);
   endtask

   task automatic push(input logic [12:0] pc);
      notes.push_back({pc, ew, 5'h00, ef});
   endtask

   // ----------------------------------------------------------------
   // watcher: one note per program counter step
   // ----------------------------------------------------------------
   initial begin
      logic [PC_W-1:0] last_pc;
      logic            first;
      int              k;
      last_pc = '0;
      first = 1'b1;
      k = 0;
      forever begin
         @(negedge ref_clk_i);
         if (run_chk) begin
            if (pmem_addr !== last_pc) begin
               if (!first)
                  check(32'(k), 32'd4);
               first = 1'b0;
               last_pc = pmem_addr;
               k = 0;
               if (notes.size() == 0) begin
                  miscompares++;
                  $display("[ERR] t=%0t got=%h exp=%h", $time, pmem_addr, 0);
               end else begin
                  check({pmem_addr, w_acc, status}, notes.pop_front());
               end
            end
            if (!first)
               check(32'(clk_out), 32'(k >= 2));
            k++;
         end
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [13:0] wd;
      logic [7:0]  fv;
      int          e;
      int          n;
      repeat (16) @(posedge ref_clk_i);
      for (int i = 0; i < NRAND; i++)
         u_mem.mem[i] = {2'b01, ops[$unsigned($random(seed)) % 6],
                         8'($random(seed))};
      u_mem.mem[24] = 14'h1401;
      u_mem.mem[25] = 14'h301e;
      u_mem.mem[26] = 14'h1300;
      u_mem.mem[27] = 14'h3028;
      u_mem.mem[28] = 14'h1fee;
      u_mem.mem[40] = 14'h1f55;
      u_mem.mem[41] = 14'h1255;
      // plain goto, then pointer set to zero so the indirect write is dropped, then a direct read of 0x55
      u_mem.mem[42] = 14'h202c;
      u_mem.mem[44] = 14'h0c84;
      u_mem.mem[45] = 14'h0c80;
      u_mem.mem[46] = 14'h1f00;
      u_mem.mem[47] = 14'h0b55;
      ew = 8'h00;
      ef = '0;
      push(13'h0001);
      e = 0;
      while (e < LAST) begin
         wd = u_mem.mem[e];
         if (wd[13:12] == CLS_LIT)
            exec(wd);
         if (wd[13:8] == 6'h0c)
            fv = ew;
         if (wd[13:8] == 6'h0b) begin
            ew = fv;
            ef.z = (ew == 8'h00);
         end
         // taken branch adds one refetch cycle
         if (wd[13:12] == CLS_GOTO || (wd[13:12] == CLS_GOTOZ && ef.z)) begin
            push({2'b00, wd[10:0]});
            push({2'b00, wd[10:0]} + 13'h0001);
            e = int'(wd[10:0]);
         end else begin
            push(13'(e + 2));
            e++;
         end
      end
      rst_i <= 1'b0;
      run_chk <= 1'b1;
      for (n = 0; n < 2000 && notes.size() > 0; n++)
         @(posedge ref_clk_i);
      if (notes.size() > 0) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, notes.size(), 0);
      end else begin
         @(posedge ref_clk_i);
         run_chk <= 1'b0;
         rc_mode <= 1'b0;
         master_clear_n_n <= 1'b0;
         repeat (8) @(posedge ref_clk_i);
         @(negedge ref_clk_i);
         check({pmem_addr, status, w_acc}, {13'h0000, 8'h00, ew});
         // running again, so a clock out ignoring the mode would show
         @(posedge ref_clk_i);
         master_clear_n_n <= 1'b1;
         repeat (8) @(posedge ref_clk_i);
         for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk_i);
            check(32'(clk_out), 32'h0);
         end
         check(32'(pmem_addr), 32'h2);
      end
      final_report();
   end
endmodule
`default_nettype wire
